// ---- verilog/qctu_defines.svh ----
`ifndef QCTU_DEFINES_SVH
`define QCTU_DEFINES_SVH

// ************************************************
// clock and external event timing
// ************************************************
`define QCTU_SYSCLK_PERIOD_NS 4
`define QCTU_EVENT_RATE_DIV 4
`define QCTU_MIN_LEVEL_CYCLES 2

// ************************************************
// prescaler and divider counts
// ************************************************
`define QCTU_DIV4_LAST 2'h3
`define QCTU_DIV12_LAST 6'h0B
`define QCTU_DIV48_LAST 6'h2F
`define QCTU_EXT_DIV8_LAST 3'h7

// ************************************************
// prescale select codes
// ************************************************
`define QCTU_PRESCALE_DIV12 2'h0
`define QCTU_PRESCALE_DIV4 2'h1
`define QCTU_PRESCALE_DIV48 2'h2
`define QCTU_PRESCALE_EXT8 2'h3

// ************************************************
// flag positions and reset values
// ************************************************
`define QCTU_FLAG_T0 0
`define QCTU_FLAG_T1 1
`define QCTU_FLAG_T2L 2
`define QCTU_FLAG_T2H 3
`define QCTU_FLAG_T3L 4
`define QCTU_FLAG_T3H 5
`define QCTU_COUNT_RESET 16'h0000
`define QCTU_FLAGS_RESET 6'h00

`endif

// ---- verilog/qctu_pkg.sv ----
package qctu_pkg;

	// ************************************************
	// timer 0/1 operating modes
	// ************************************************
	typedef enum logic [1:0] {
		QCTU_MODE_13BIT,
		QCTU_MODE_16BIT,
		QCTU_MODE_8BIT_RELOAD,
		QCTU_MODE_SPLIT
	} qctu_t01_mode_type;

	typedef struct packed {
		logic [15:0] t0;
		logic [15:0] t1;
		logic [15:0] t2;
		logic [15:0] t3;
		logic [5:0] flags;
		logic [1:0] div4;
		logic [5:0] div12;
		logic [5:0] div48;
		logic [2:0] ext_div;
		logic wake;
		logic irq;
	} qctu_state_type;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic fall;
	} qctu_sync_type;

endpackage : qctu_pkg

// ---- verilog/qctu_fall_sync.sv ----
`timescale 1ns/1ns
// ************************************************
// two-flop synchroniser with falling edge pulse
// ************************************************
module qctu_fall_sync (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_pin,
	output logic o_level,
	output logic o_fall
);
	qctu_pkg::qctu_sync_type state_reg;
	qctu_pkg::qctu_sync_type state_next;

	always_comb begin
		state_next = state_reg;
		state_next.s1 = i_pin;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		// one pulse per edge, needs each level held two cycles
		state_next.fall = state_reg.s3 & ~state_reg.s2;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_level = state_reg.s2;
	assign o_fall = state_reg.fall;
endmodule : qctu_fall_sync

// ---- verilog/qctu_timer_unit.sv ----
`timescale 1ns/1ns
`include "qctu_defines.svh"
// Overview of operation
// - four counter/timers are provided, two classic 16-bit timers and two 16-bit auto-reload timers.
// - timers 0 and 1 run in 13-bit, 16-bit or 8-bit auto-reload mode, and timer 0 alone can split in two bytes.
// - timers 2 and 3 run as one 16-bit auto-reload timer or as two 8-bit timers each with its own reload.
// - timer 3 keeps counting the external oscillator in suspend and its overflow wakes the device.
// - timers 0 and 1 take one of five clocks chosen by their sysclk select bits and the prescale field.
// - each of timers 0 and 1 independently counts the prescaled clock or the raw system clock.
// - timers 2 and 3 count the system clock, the system clock over 12, or the external clock over 8.
// - in counter mode timers 0 and 1 advance once per falling edge on their count input.
// - external events are counted reliably only up to a quarter of the system clock rate.
// - prescale codes give system clock over 12, 4, 48, or external clock over 8 synchronised.
// - the sysclk select bit picks the system clock when set and is ignored in counter mode.
// - a 13-bit wrap from all ones to zero sets the overflow flag and requests an interrupt when enabled.
// - a timer runs only when its run control is set and its gate is off or its interrupt input is active.
module qctu_timer_unit (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_count_input_zero,
	input wire logic i_count_input_one,
	input wire logic i_ext_osc_clk,
	input wire logic i_external_interrupt_input_zero,
	input wire logic i_external_interrupt_input_one,
	input wire logic [1:0] i_int_active_level,
	input wire logic [1:0] i_timer0_mode,
	input wire logic [1:0] i_timer1_mode,
	input wire logic [1:0] i_counter_mode,
	input wire logic [1:0] i_gate_enable,
	input wire logic [3:0] i_run_control,
	input wire logic i_timer0_sysclk_select,
	input wire logic i_timer1_sysclk_select,
	input wire logic [1:0] i_prescale_select,
	input wire logic [1:0] i_t23_split,
	input wire logic [1:0] i_t23_ext_clock,
	input wire logic [1:0] i_t23_low_sysclk,
	input wire logic [1:0] i_t23_high_sysclk,
	input wire logic [15:0] i_timer2_reload,
	input wire logic [15:0] i_timer3_reload,
	input wire logic [3:0] i_load_select,
	input wire logic [15:0] i_load_value,
	input wire logic [5:0] i_flag_clear,
	input wire logic [5:0] i_irq_enable,
	input wire logic i_suspend,
	output logic [15:0] o_timer0_count,
	output logic [15:0] o_timer1_count,
	output logic [15:0] o_timer2_count,
	output logic [15:0] o_timer3_count,
	output logic [5:0] o_overflow_flags,
	output logic o_timer_irq,
	output logic o_wake
);
	qctu_pkg::qctu_state_type state_reg;
	qctu_pkg::qctu_state_type state_next;
	logic cnt0_fall, cnt1_fall;
	logic ext_fall, external_interrupt_input_zero_level, int1_level;

	// ************************************************
	// input synchronisers
	// ************************************************
	qctu_fall_sync u_sync_cnt0 (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_count_input_zero),
		.o_level(), .o_fall(cnt0_fall));
	qctu_fall_sync u_sync_cnt1 (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_count_input_one),
		.o_level(), .o_fall(cnt1_fall));
	qctu_fall_sync u_sync_ext (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_ext_osc_clk),
		.o_level(), .o_fall(ext_fall));
	qctu_fall_sync u_sync_external_interrupt_input_zero (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_external_interrupt_input_zero),
		.o_level(external_interrupt_input_zero_level), .o_fall());
	qctu_fall_sync u_sync_int1 (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pin(i_external_interrupt_input_one),
		.o_level(int1_level), .o_fall());

	// ************************************************
	// step functions
	// ************************************************
	// returns {overflow, value}; split mode moves only the low byte here
	function automatic logic [16:0] step_t01(input logic [15:0] v, input logic [1:0] mode);
		logic [16:0] r;
		r = {1'b0, v};
		case (qctu_pkg::qctu_t01_mode_type'(mode))
			qctu_pkg::QCTU_MODE_13BIT: begin
				// upper three low-byte bits are left untouched
				r = {({v[15:8], v[4:0]} == 13'h1FFF), v[15:8] + {7'h00, (v[4:0] == 5'h1F)}, v[7:5], v[4:0] + 5'h01};
			end
			qctu_pkg::QCTU_MODE_16BIT: begin
				r = {(v == 16'hFFFF), v + 16'h0001};
			end
			qctu_pkg::QCTU_MODE_8BIT_RELOAD: begin
				r = (v[7:0] == 8'hFF) ? {1'b1, v[15:8], v[15:8]} : {1'b0, v[15:8], v[7:0] + 8'h01};
			end
			default: begin
				r = {(v[7:0] == 8'hFF), v[15:8], v[7:0] + 8'h01};
			end
		endcase
		return r;
	endfunction : step_t01

	// returns {high overflow, low overflow, value}
	function automatic logic [17:0] step_t23(input logic [15:0] v, input logic [15:0] rl, input logic split,
		input logic tl, input logic th);
		logic [17:0] r;
		r = {2'b00, v};
		if (!split) begin
			if (tl) begin
				r = (v == 16'hFFFF) ? {2'b10, rl} : {2'b00, v + 16'h0001};
			end
		end else begin
			if (tl) begin
				r[16] = (v[7:0] == 8'hFF);
				r[7:0] = r[16] ? rl[7:0] : v[7:0] + 8'h01;
			end
			if (th) begin
				r[17] = (v[15:8] == 8'hFF);
				r[15:8] = r[17] ? rl[15:8] : v[15:8] + 8'h01;
			end
		end
		return r;
	endfunction : step_t23

	// ************************************************
	// next state
	// ************************************************
	logic d4, d12, d48, ext8, pre_tick, awake, run0, run1, tick0, tick0h, tick1;
	logic base2, base3, tl2, th2, tl3, th3, t0_split;
	logic [16:0] s0, s1;
	logic [17:0] s2, s3;
	logic [5:0] set_flags;

	always_comb begin
		state_next = state_reg;
		d4 = (state_reg.div4 == `QCTU_DIV4_LAST);
		d12 = (state_reg.div12 == `QCTU_DIV12_LAST);
		d48 = (state_reg.div48 == `QCTU_DIV48_LAST);
		ext8 = ext_fall && (state_reg.ext_div == `QCTU_EXT_DIV8_LAST);
		state_next.div4 = state_reg.div4 + 2'h1;
		state_next.div12 = d12 ? 6'h00 : state_reg.div12 + 6'h01;
		state_next.div48 = d48 ? 6'h00 : state_reg.div48 + 6'h01;
		state_next.ext_div = state_reg.ext_div + {2'h0, ext_fall};
		case (i_prescale_select)
			`QCTU_PRESCALE_DIV12: pre_tick = d12;
			`QCTU_PRESCALE_DIV4: pre_tick = d4;
			`QCTU_PRESCALE_DIV48: pre_tick = d48;
			default: pre_tick = ext8;
		endcase
		awake = !i_suspend;
		// gate lets an interrupt input level hold the timer off
		run0 = i_run_control[0] && (!i_gate_enable[0] || (external_interrupt_input_zero_level == i_int_active_level[0]));
		run1 = i_run_control[1] && (!i_gate_enable[1] || (int1_level == i_int_active_level[1]));
		// five sources: four prescale codes plus raw sysclk
		tick0 = awake && run0 && (i_counter_mode[0] ? cnt0_fall : (i_timer0_sysclk_select || pre_tick));
		tick1 = awake && run1 && (i_counter_mode[1] ? cnt1_fall : (i_timer1_sysclk_select || pre_tick));
		// split timer 0 high byte borrows timer 1 run control, as a timer only
		t0_split = (i_timer0_mode == 2'h3);
		tick0h = awake && t0_split && i_run_control[1] && (i_timer1_sysclk_select || pre_tick);
		s0 = step_t01(state_reg.t0, i_timer0_mode);
		s1 = step_t01(state_reg.t1, i_timer1_mode);
		set_flags = 6'h00;
		if (tick0) begin
			state_next.t0[7:0] = s0[7:0];
			if (!t0_split) begin
				state_next.t0[15:8] = s0[15:8];
			end
			set_flags[`QCTU_FLAG_T0] = s0[16];
		end
		if (tick0h) begin
			state_next.t0[15:8] = state_reg.t0[15:8] + 8'h01;
			set_flags[`QCTU_FLAG_T1] = (state_reg.t0[15:8] == 8'hFF);
		end
		// timer 1 split mode holds its count; it has no split of its own
		if (tick1 && (i_timer1_mode != 2'h3)) begin
			state_next.t1 = s1[15:0];
			if (!t0_split) begin
				set_flags[`QCTU_FLAG_T1] = s1[16];
			end
		end
		// timers 2 and 3: sysclk, sysclk over 12 or external over 8
		base2 = i_t23_ext_clock[0] ? ext8 : d12;
		base3 = i_t23_ext_clock[1] ? ext8 : d12;
		tl2 = awake && i_run_control[2] && (i_t23_low_sysclk[0] || base2);
		th2 = awake && i_run_control[2] && (i_t23_high_sysclk[0] || base2);
		// in suspend only the external divider tick still advances timer 3
		tl3 = i_run_control[3] && (i_suspend ? (i_t23_ext_clock[1] && ext8) : (i_t23_low_sysclk[1] || base3));
		th3 = i_run_control[3] && (i_suspend ? (i_t23_ext_clock[1] && ext8) : (i_t23_high_sysclk[1] || base3));
		s2 = step_t23(state_reg.t2, i_timer2_reload, i_t23_split[0], tl2, th2);
		s3 = step_t23(state_reg.t3, i_timer3_reload, i_t23_split[1], tl3, th3);
		state_next.t2 = s2[15:0];
		state_next.t3 = s3[15:0];
		set_flags[`QCTU_FLAG_T2L] = s2[16];
		set_flags[`QCTU_FLAG_T2H] = s2[17];
		set_flags[`QCTU_FLAG_T3L] = s3[16];
		set_flags[`QCTU_FLAG_T3H] = s3[17];
		state_next.wake = i_suspend && (s3[16] || s3[17]);
		// software load wins over a count in the same cycle
		if (i_load_select[0]) state_next.t0 = i_load_value;
		if (i_load_select[1]) state_next.t1 = i_load_value;
		if (i_load_select[2]) state_next.t2 = i_load_value;
		if (i_load_select[3]) state_next.t3 = i_load_value;
		// set beats clear so no overflow is lost
		state_next.flags = (state_reg.flags & ~i_flag_clear) | set_flags;
		state_next.irq = |(state_next.flags & i_irq_enable);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_reg <= '0;
			state_reg.t0 <= `QCTU_COUNT_RESET;
			state_reg.t1 <= `QCTU_COUNT_RESET;
			state_reg.t2 <= `QCTU_COUNT_RESET;
			state_reg.t3 <= `QCTU_COUNT_RESET;
			state_reg.flags <= `QCTU_FLAGS_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// four counters exposed straight from the state flops
	assign o_timer0_count = state_reg.t0;
	assign o_timer1_count = state_reg.t1;
	assign o_timer2_count = state_reg.t2;
	assign o_timer3_count = state_reg.t3;
	assign o_overflow_flags = state_reg.flags;
	assign o_timer_irq = state_reg.irq;
	assign o_wake = state_reg.wake;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	wrap13_flag_a: assert property (
		(i_timer0_mode == 2'h0) && tick0 && !i_load_select[0] && ({state_reg.t0[15:8], state_reg.t0[4:0]} == 13'h1FFF)
		|=> state_reg.flags[`QCTU_FLAG_T0] && ({state_reg.t0[15:8], state_reg.t0[4:0]} == 13'h0000))
		else $error("13-bit wrap did not set flag");
	counter_edge_step_a: assert property (
		(i_timer0_mode == 2'h1) && i_counter_mode[0] && run0 && awake && cnt0_fall && !i_load_select[0]
		|=> state_reg.t0 == $past(state_reg.t0) + 16'h0001)
		else $error("counter missed a falling edge");
	edge_once_a: assert property (
		cnt0_fall |=> !cnt0_fall)
		else $error("edge pulse longer than one cycle");
	gate_hold_a: assert property (
		i_gate_enable[0] && (external_interrupt_input_zero_level != i_int_active_level[0]) && !i_load_select[0] && !t0_split
		|=> state_reg.t0 == $past(state_reg.t0))
		else $error("gated timer advanced");
	prescale_div4_a: assert property (
		d4 |=> !d4 ##1 !d4 ##1 !d4 ##1 d4)
		else $error("divide by four period wrong");
	div12_period_a: assert property (
		d12 |=> !d12 [*8] ##1 !d12 [*3] ##1 d12)
		else $error("divide by twelve period wrong");
	reload16_t2_a: assert property (
		!i_t23_split[0] && tl2 && (state_reg.t2 == 16'hFFFF) && !i_load_select[2]
		|=> (state_reg.t2 == $past(i_timer2_reload)) && state_reg.flags[`QCTU_FLAG_T2H])
		else $error("timer 2 reload missed");
	suspend_freeze_a: assert property (
		i_suspend && !i_load_select[1] |=> state_reg.t1 == $past(state_reg.t1))
		else $error("timer 1 counted in suspend");
	wake_cause_a: assert property (
		o_wake |-> $past(i_suspend) && $past(state_reg.t3) != state_reg.t3)
		else $error("wake without timer 3 activity");
	sysclk_select_a: assert property (
		(i_timer1_mode == 2'h1) && !i_counter_mode[1] && i_timer1_sysclk_select && run1 && awake
		&& !i_load_select[1] |=> state_reg.t1 == $past(state_reg.t1) + 16'h0001)
		else $error("sysclk select did not count every cycle");

	t0_overflow_c: cover property (state_reg.flags[`QCTU_FLAG_T0] && o_timer_irq);
	t3_wake_c: cover property (o_wake);
	t2_split_c: cover property (i_t23_split[0] && state_reg.flags[`QCTU_FLAG_T2L]);
	ext_count_c: cover property (i_counter_mode[0] && cnt0_fall ##1 state_reg.t0 != $past(state_reg.t0));
endmodule : qctu_timer_unit

// ---- verification/qctu_pin_model.sv ----
`timescale 1ns/1ns
// ************************************************
// event pins, oscillator and gate inputs
// ************************************************
module qctu_pin_model (
	input wire logic i_clk,
	input wire logic [1:0] i_gate_level,
	output logic o_count_zero,
	output logic o_count_one,
	output logic o_ext_osc,
	output logic o_int_zero,
	output logic o_int_one
);
	logic [1:0] pin_reg;
	assign o_count_zero = pin_reg[0];
	assign o_count_one = pin_reg[1];
	assign o_int_zero = i_gate_level[0];
	assign o_int_one = i_gate_level[1];
	// oscillator free runs, half period 16 ns, edges fixed 1 ns after a rising system clock edge
	initial begin
		pin_reg = 2'h3;
		o_ext_osc = 1'b1;
		#3;
		forever #16 o_ext_osc = ~o_ext_osc;
	end
	// two cycles per level: the fastest rate still counted reliably
	task automatic pulse(input int pin, input int n);
		@(posedge i_clk);
		#1;
		repeat (n) begin
			pin_reg[pin] = 1'b0;
			repeat (2) @(posedge i_clk);
			#1;
			pin_reg[pin] = 1'b1;
			repeat (2) @(posedge i_clk);
			#1;
		end
	endtask : pulse
endmodule : qctu_pin_model

// ---- verification/tb_qctu_timer_unit.sv ----
`timescale 1ns/1ns
module tb_qctu_timer_unit;
	typedef struct {int sel; logic [15:0] val;} qctu_note_type;
	logic i_clk, i_sys_rst, i_ext_osc_clk, i_timer0_sysclk_select, i_timer1_sysclk_select, i_suspend;
	logic i_count_input_zero, i_count_input_one, i_external_interrupt_input_zero, i_external_interrupt_input_one;
	logic [1:0] i_int_active_level, i_timer0_mode, i_timer1_mode, i_counter_mode, i_gate_enable, i_prescale_select;
	logic [1:0] i_t23_split, i_t23_ext_clock, i_t23_low_sysclk, i_t23_high_sysclk, gate_lvl;
	logic [15:0] i_timer2_reload, i_timer3_reload, i_load_value, start;
	logic [15:0] o_timer0_count, o_timer1_count, o_timer2_count, o_timer3_count;
	logic [3:0] i_run_control, i_load_select;
	logic [5:0] i_flag_clear, i_irq_enable, o_overflow_flags;
	logic o_timer_irq, o_wake;
	int miscompares = 0;
	int n_compared = 0;
	int wake_cnt = 0;
	int k;
	int divs[4] = '{12, 4, 48, 64};
	string names[7] = '{"count0", "count1", "count2", "count3", "flags", "irq", "wakes"};
	qctu_note_type notes[$];
	qctu_note_type cur;
	logic [15:0] obs[7];
	qctu_timer_unit uut (.*);
	qctu_pin_model pins (.i_clk(i_clk), .i_gate_level(gate_lvl), .o_count_zero(i_count_input_zero),
		.o_count_one(i_count_input_one), .o_ext_osc(i_ext_osc_clk), .o_int_zero(i_external_interrupt_input_zero),
		.o_int_one(i_external_interrupt_input_one));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc
	task automatic note(input int sel, input logic [15:0] val);
		notes.push_back('{sel, val});
	endtask : note
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic load(input int n, input logic [15:0] v);
		i_load_value = v;
		i_load_select = 4'h1 << n;
		cyc(1);
		i_load_select = 4'h0;
	endtask : load
	task automatic run_for(input int n, input int cycles);
		i_run_control[n] = 1'b1;
		cyc(cycles);
		i_run_control[n] = 1'b0;
	endtask : run_for
	task automatic clear_flags();
		i_flag_clear = 6'h3F;
		cyc(1);
		i_flag_clear = 6'h00;
	endtask : clear_flags
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	// ************************************************
	// monitor: outputs settle by the falling edge
	// ************************************************
	always @(negedge i_clk) begin
		if (o_wake === 1'b1) begin
			wake_cnt++;
		end
		obs = '{o_timer0_count, o_timer1_count, o_timer2_count, o_timer3_count, {10'h000, o_overflow_flags},
			{15'h0000, o_timer_irq}, wake_cnt[15:0]};
		while (notes.size() > 0) begin
			cur = notes.pop_front();
			check(names[cur.sel], obs[cur.sel], cur.val);
		end
	end
	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		{i_sys_rst, i_timer0_sysclk_select, i_timer1_sysclk_select, i_suspend} = 4'hF;
		{i_int_active_level, i_timer0_mode, i_timer1_mode, i_counter_mode, i_gate_enable} = 10'h050;
		{i_prescale_select, i_t23_split, i_t23_ext_clock, i_t23_low_sysclk, i_t23_high_sysclk, gate_lvl} = 12'h000;
		{i_timer2_reload, i_timer3_reload, i_load_value} = 48'h0;
		{i_run_control, i_load_select, i_flag_clear, i_irq_enable} = 20'h0;
		i_suspend = 1'b0;
		repeat (12) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		void'($urandom(32'h63FE2E1A));
		for (k = 0; k < 6; k++) note(k, 16'h0000);
		cyc(1);
		$display("test reset done");
		for (int n = 0; n < 2; n++) begin
			start = 16'($urandom_range(16'hFF00));
			load(n, start);
			note(n, start);
			i_timer0_sysclk_select = (n == 0);
			i_timer1_sysclk_select = (n == 1);
			run_for(n, 37);
			note(n, start + 16'h0025);
		end
		$display("test sysclk done");
		i_timer0_sysclk_select = 1'b0;
		for (int c = 0; c < 4; c++) begin
			i_prescale_select = c[1:0];
			load(0, 16'h0000);
			run_for(0, divs[c] * 10);
			note(0, 16'h000A);
		end
		$display("test prescale done");
		i_timer0_sysclk_select = 1'b1;
		i_timer1_sysclk_select = 1'b1;
		for (int n = 0; n < 2; n++) begin
			i_counter_mode = 2'h1 << n;
			load(n, 16'h0000);
			i_run_control[n] = 1'b1;
			pins.pulse(n, 9);
			cyc(6);
			i_run_control[n] = 1'b0;
			note(n, 16'h0009);
		end
		i_counter_mode = 2'h0;
		$display("test counter done");
		i_timer0_mode = 2'h0;
		i_irq_enable = 6'h01;
		load(0, 16'hFFFE);
		run_for(0, 2);
		cyc(1);
		note(0, 16'h00E0);
		note(4, 16'h0001);
		note(5, 16'h0001);
		clear_flags();
		note(5, 16'h0000);
		i_timer0_mode = 2'h2;
		load(0, 16'hF0FE);
		run_for(0, 3);
		note(0, 16'hF0F1);
		clear_flags();
		i_timer0_mode = 2'h3;
		load(0, 16'h10FE);
		i_run_control = 4'h3;
		cyc(3);
		i_run_control = 4'h0;
		cyc(1);
		note(0, 16'h1301);
		note(4, 16'h0001);
		i_timer0_mode = 2'h1;
		i_timer1_mode = 2'h0;
		i_irq_enable = 6'h02;
		clear_flags();
		load(1, 16'hFFFF);
		run_for(1, 1);
		cyc(1);
		note(1, 16'h00E0);
		note(4, 16'h0002);
		note(5, 16'h0001);
		i_timer1_mode = 2'h3;
		run_for(1, 5);
		note(1, 16'h00E0);
		i_timer1_mode = 2'h1;
		$display("test modes done");
		i_gate_enable = 2'h1;
		gate_lvl = 2'h3;
		cyc(4);
		load(0, 16'h0000);
		for (int g = 0; g < 3; g++) begin
			gate_lvl = (g == 0) ? 2'h3 : 2'h0;
			i_int_active_level = (g == 2) ? 2'h1 : 2'h0;
			cyc(4);
			run_for(0, 20);
			note(0, (g == 0) ? 16'h0000 : 16'h0014);
		end
		i_gate_enable = 2'h0;
		$display("test gate done");
		clear_flags();
		i_t23_low_sysclk = 2'h1;
		i_timer2_reload = 16'hFFF0;
		load(2, 16'hFFFE);
		run_for(2, 3);
		cyc(1);
		note(2, 16'hFFF1);
		note(4, 16'h0008);
		clear_flags();
		{i_t23_split, i_t23_low_sysclk, i_t23_high_sysclk} = 6'h2A;
		i_timer3_reload = 16'h80F0;
		load(3, 16'h00FE);
		run_for(3, 3);
		cyc(1);
		note(3, 16'h03F1);
		note(4, 16'h0010);
		clear_flags();
		{i_t23_split, i_t23_low_sysclk, i_t23_high_sysclk} = 6'h15;
		i_timer2_reload = 16'h7070;
		load(2, 16'h05FE);
		run_for(2, 3);
		cyc(1);
		note(2, 16'h0871);
		note(4, 16'h0004);
		{i_t23_split, i_t23_low_sysclk, i_t23_high_sysclk} = 6'h00;
		load(2, 16'h0000);
		run_for(2, 120);
		note(2, 16'h000A);
		i_t23_ext_clock = 2'h2;
		load(3, 16'h0000);
		run_for(3, 640);
		note(3, 16'h000A);
		$display("test timer23 done");
		i_timer3_reload = 16'h0000;
		load(3, 16'hFFFF);
		cyc(1);
		load(0, 16'h1234);
		wake_cnt = 0;
		i_suspend = 1'b1;
		i_run_control = 4'h9;
		// wake must come within 200 cycles, just over three external-over-8 ticks
		for (k = 0; k < 200 && wake_cnt == 0; k++) cyc(1);
		i_run_control = 4'h0;
		i_suspend = 1'b0;
		note(0, 16'h1234);
		note(6, 16'h0001);
		if (wake_cnt == 0) begin
			$display("Error wake timeout expected 1 seen 0");
			miscompares++;
		end
		$display("test suspend done");
		cyc(2);
		report_and_stop();
	end
endmodule : tb_qctu_timer_unit
